// ==== hdl/stp_regs.svh ====
/*
  Register map, field positions, reset values and rate figures of the
  16-bit prescaled timer.
  Assumes inclusion by bare name from the timer package and design file.
*/
`ifndef STP_REGS_SVH
`define STP_REGS_SVH

// ***************************************************
// register byte addresses on the apb bus
// ***************************************************
`define STP_ADDR_CTRL  8'h00
`define STP_ADDR_LOW   8'h04
`define STP_ADDR_HIGH  8'h08
`define STP_ADDR_FLAGS 8'h0c
`define STP_ADDR_IEN   8'h10
`define STP_ADDR_ICTL  8'h14

// ***************************************************
// field positions
// ***************************************************
`define STP_CTRL_ON    0
`define STP_CTRL_CS    1
`define STP_CTRL_PS_LO 4
`define STP_CTRL_PS_HI 5
`define STP_FLAG_ROLL  0
`define STP_IEN_ROLL   0
`define STP_ICTL_PERIPHERAL_INTERRUPT_ENABLE  6
`define STP_ICTL_GIE   7

// ***************************************************
// reset values
// ***************************************************
`define STP_RST_BYTE   8'h00
`define STP_RST_COUNT  16'h0000

// ***************************************************
// rates in mhz
// ***************************************************
`define STP_REF_MHZ    125
`define STP_OSC_MHZ    8
`define STP_INST_MHZ   2

`endif

// ==== hdl/stp_pkg.sv ====
/*
  Types shared by the 16-bit prescaled timer.
  Assumes stp_regs.svh is on the include path.
*/
package stp_pkg;
  `include "stp_regs.svh"

  typedef logic [7:0] stp_byte_t;

  typedef enum logic [1:0] {
    APB_IDLE,
    APB_WAIT,
    APB_RESP
  } stp_apb_e;
endpackage

// ==== hdl/stp_timer.sv ====
/*
  16-bit free-running up-counter with source select, 2-bit prescaler,
  rollover flag and gated interrupt request, reached over apb.
  Assumes a 125 mhz i_ref_clk, synchronous i_sleep and a standard apb master.
*/
// Decided for this implementation: the register offsets and the APB register port.
// Operation
// - 16-bit counter as two bytes; a byte write replaces that counter byte at once.
// - Counter advances only while timer_on_bit (control bit 0) is one.
// - clock_source_select bit 1: one counts 8 MHz oscillator, zero 2 MHz.
// - prescale_field bits 5-4 divide the source by 1, 2, 4 or 8.
// - Prescale counter is hidden and cleared by any counter byte write.
// - Past FFFFh the counter wraps to 0000h and sets rollover_flag unless a counter byte write lands in that cycle.
// - Interrupt only when on, rollover, peripheral and global enables are set.
// - rollover_flag stays set until software writes zero to it.
// - Writing timer_on_bit zero stops counting and clears the gate flip-flop.
// - Internal clocks only: frozen in sleep, never wakes the processor.
// - Control bits 7-6 and 3-2 read zero; control bits reset to zero.
`include "stp_regs.svh"

module stp_timer (
  // clock and reset
  input  wire logic           i_ref_clk,
  input  wire logic           i_rst_n,
  // processor state
  input  wire logic           i_sleep,
  // apb slave
  input  wire logic           i_psel,
  input  wire logic           i_penable,
  input  wire logic           i_pwrite,
  input  wire logic [7:0]     i_paddr,
  input  wire logic [31:0]    i_pwdata,
  output logic      [31:0]    o_prdata,
  output logic                o_pready,
  output logic                o_pslverr,
  // interrupt request
  output logic                o_irq
);
  import stp_pkg::*;

  // ***************************************************
  // helpers
  // ***************************************************
  function automatic logic [2:0] ps_mask(input logic [1:0] sel);
    case (sel)
      2'h0:    ps_mask = 3'h0;
      2'h1:    ps_mask = 3'h1;
      2'h2:    ps_mask = 3'h3;
      default: ps_mask = 3'h7;
    endcase
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `STP_ADDR_CTRL) || (a == `STP_ADDR_LOW) ||
               (a == `STP_ADDR_HIGH) || (a == `STP_ADDR_FLAGS) ||
               (a == `STP_ADDR_IEN) || (a == `STP_ADDR_ICTL);
  endfunction

  localparam logic [7:0] OSC_STEP = 8'(`STP_OSC_MHZ);
  localparam logic [7:0] REF_MOD  = 8'(`STP_REF_MHZ);
  localparam logic [1:0] INST_TOP = 2'(`STP_OSC_MHZ / `STP_INST_MHZ - 1);

  // ***************************************************
  // state
  // ***************************************************
  stp_apb_e   apb_st;
  stp_apb_e   next_apb_st;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  stp_byte_t   ctrl;
  stp_byte_t   next_ctrl;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [2:0]  ps_cnt;
  logic [2:0]  next_ps_cnt;
  logic        gate_ff;
  logic        next_gate_ff;
  logic        roll_flag;
  logic        next_roll_flag;
  logic        roll_en;
  logic        next_roll_en;
  logic        peripheral_interrupt_enable;
  logic        next_peripheral_interrupt_enable;
  logic        global_interrupt_enable;
  logic        next_gie;
  logic [7:0]  osc_acc;
  logic [7:0]  next_osc_acc;
  logic        osc_tick;
  logic        next_osc_tick;
  logic [1:0]  inst_cnt;
  logic [1:0]  next_inst_cnt;
  logic        inst_tick;
  logic        next_inst_tick;
  logic        next_irq;

  logic        wr_done;
  logic [7:0]  wbyte;
  logic        wr_count;
  logic        src_tick;
  logic        step;
  logic        roll;
  stp_byte_t   rd_mux;

  assign wr_done  = i_psel && i_penable && o_pready && i_pwrite;
  assign wbyte    = i_pwdata[7:0];
  assign wr_count = wr_done && (i_paddr == `STP_ADDR_LOW || i_paddr == `STP_ADDR_HIGH);

  // ***************************************************
  // apb slave: one wait cycle, read data captured on the same edge as ready
  // ***************************************************
  always_comb begin
    rd_mux = `STP_RST_BYTE;
    case (i_paddr)
      `STP_ADDR_CTRL:  rd_mux = ctrl;
      `STP_ADDR_LOW:   rd_mux = count[7:0];
      `STP_ADDR_HIGH:  rd_mux = count[15:8];
      `STP_ADDR_FLAGS: rd_mux = {7'h00, roll_flag};
      `STP_ADDR_IEN:   rd_mux = {7'h00, roll_en};
      `STP_ADDR_ICTL:  rd_mux = {global_interrupt_enable, peripheral_interrupt_enable, 6'h00};
      default:         rd_mux = `STP_RST_BYTE;
    endcase
  end

  always_comb begin
    next_apb_st  = apb_st;
    next_prdata  = o_prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    case (apb_st)
      APB_IDLE: begin
        if (i_psel && !i_penable) begin
          next_apb_st = APB_WAIT;
        end
      end
      APB_WAIT: begin
        next_apb_st  = APB_RESP;
        next_pready  = 1'b1;
        next_pslverr = !addr_hit(i_paddr);
        next_prdata  = i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
      end
      APB_RESP: begin
        next_apb_st = APB_IDLE;
      end
      default: begin
        next_apb_st = APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      apb_st    <= APB_IDLE;
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      apb_st    <= next_apb_st;
      o_prdata  <= next_prdata;
      o_pready  <= next_pready;
      o_pslverr <= next_pslverr;
    end
  end

  // ***************************************************
  // timer: source ticks, prescaler, counter, flags
  // ***************************************************
  always_comb begin
    next_osc_acc   = osc_acc + OSC_STEP;
    next_osc_tick  = 1'b0;
    if (next_osc_acc >= REF_MOD) begin
      next_osc_acc  = next_osc_acc - REF_MOD;
      next_osc_tick = 1'b1;
    end
    next_inst_cnt  = inst_cnt;
    next_inst_tick = 1'b0;
    if (osc_tick) begin
      next_inst_cnt  = inst_cnt + 2'h1;
      next_inst_tick = (inst_cnt == INST_TOP);
    end
    src_tick = ctrl[`STP_CTRL_CS] ? osc_tick : inst_tick;
    step     = ctrl[`STP_CTRL_ON] && gate_ff && !i_sleep && src_tick;
    roll     = 1'b0;

    next_ctrl      = ctrl;
    next_count     = count;
    next_ps_cnt    = ps_cnt;
    next_gate_ff   = gate_ff | ctrl[`STP_CTRL_ON];
    next_roll_flag = roll_flag;
    next_roll_en   = roll_en;
    next_peripheral_interrupt_enable      = peripheral_interrupt_enable;
    next_gie       = global_interrupt_enable;

    if (step) begin
      if (ps_cnt >= ps_mask(ctrl[`STP_CTRL_PS_HI:`STP_CTRL_PS_LO])) begin
        next_ps_cnt = 3'h0;
        next_count  = count + 16'h0001;
        roll        = (count == 16'hffff);
      end else begin
        next_ps_cnt = ps_cnt + 3'h1;
      end
    end

    if (wr_done) begin
      case (i_paddr)
        `STP_ADDR_CTRL: begin
          next_ctrl = {2'h0, wbyte[5:4], 2'h0, wbyte[1:0]};
          if (!wbyte[`STP_CTRL_ON]) begin
            next_gate_ff = 1'b0;
          end
        end
        `STP_ADDR_LOW: begin
          next_count[7:0] = wbyte;
        end
        `STP_ADDR_HIGH: begin
          next_count[15:8] = wbyte;
        end
        `STP_ADDR_FLAGS: begin
          next_roll_flag = wbyte[`STP_FLAG_ROLL];
        end
        `STP_ADDR_IEN: begin
          next_roll_en = wbyte[`STP_IEN_ROLL];
        end
        `STP_ADDR_ICTL: begin
          next_peripheral_interrupt_enable = wbyte[`STP_ICTL_PERIPHERAL_INTERRUPT_ENABLE];
          next_gie  = wbyte[`STP_ICTL_GIE];
        end
        default: begin
          next_ctrl = ctrl;
        end
      endcase
    end
    if (wr_count) begin
      next_ps_cnt = 3'h0;
    end
    if (roll && !wr_count) begin
      next_roll_flag = 1'b1;
    end
    next_irq = roll_flag && roll_en && peripheral_interrupt_enable && global_interrupt_enable && ctrl[`STP_CTRL_ON];
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl      <= `STP_RST_BYTE;
      count     <= `STP_RST_COUNT;
      ps_cnt    <= 3'h0;
      gate_ff   <= 1'b0;
      roll_flag <= 1'b0;
      roll_en   <= 1'b0;
      peripheral_interrupt_enable      <= 1'b0;
      global_interrupt_enable       <= 1'b0;
      osc_acc   <= 8'h00;
      osc_tick  <= 1'b0;
      inst_cnt  <= 2'h0;
      inst_tick <= 1'b0;
      o_irq     <= 1'b0;
    end else begin
      ctrl      <= next_ctrl;
      count     <= next_count;
      ps_cnt    <= next_ps_cnt;
      gate_ff   <= next_gate_ff;
      roll_flag <= next_roll_flag;
      roll_en   <= next_roll_en;
      peripheral_interrupt_enable      <= next_peripheral_interrupt_enable;
      global_interrupt_enable       <= next_gie;
      osc_acc   <= next_osc_acc;
      osc_tick  <= next_osc_tick;
      inst_cnt  <= next_inst_cnt;
      inst_tick <= next_inst_tick;
      o_irq     <= next_irq;
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  a_low_write: assert property (
    wr_done && i_paddr == `STP_ADDR_LOW |=> count[7:0] == $past(i_pwdata[7:0]))
    else $error("low byte write not applied");

  a_hold_off: assert property (
    !ctrl[`STP_CTRL_ON] && !wr_count |=> count == $past(count) && ps_cnt == $past(ps_cnt))
    else $error("counter moved while off");

  a_inst_rate: assert property (
    inst_tick |=> !inst_tick [*8] ##1 !inst_tick [*7])
    else $error("instruction tick spaced too closely");

  a_ps_bound: assert property (
    step && !wr_done |=> ps_cnt <= ps_mask(ctrl[`STP_CTRL_PS_HI:`STP_CTRL_PS_LO]))
    else $error("prescale counter beyond its division");

  a_ps_clear: assert property (
    wr_count |=> ps_cnt == 3'h0)
    else $error("prescaler not cleared by counter write");

  a_wrap_flag: assert property (
    step && count == 16'hffff && ps_cnt >= ps_mask(ctrl[5:4]) && !wr_done
    |=> count == 16'h0000 && roll_flag)
    else $error("rollover did not wrap and flag");

  a_irq_gate: assert property (
    o_irq |-> $past(roll_flag && roll_en && peripheral_interrupt_enable && global_interrupt_enable && ctrl[`STP_CTRL_ON]))
    else $error("interrupt without all enables");

  a_flag_sticky: assert property (
    roll_flag && !(wr_done && i_paddr == `STP_ADDR_FLAGS) |=> roll_flag)
    else $error("rollover flag dropped by itself");

  a_gate_clear: assert property (
    wr_done && i_paddr == `STP_ADDR_CTRL && !i_pwdata[0] |=> !gate_ff ##1 !gate_ff)
    else $error("gate flip-flop not cleared");

  a_sleep_freeze: assert property (
    i_sleep && !wr_count |=> count == $past(count))
    else $error("counter moved in sleep");

  a_ctrl_reserved: assert property (
    o_pready && !i_pwrite && i_paddr == `STP_ADDR_CTRL |-> o_prdata[7:6] == 2'h0 &&
    o_prdata[3:2] == 2'h0)
    else $error("reserved control bits read nonzero");
endmodule

// ==== sim/tb_stp_timer.sv ====
/*
  Self-checking bench for the prescaled timer: apb master tasks and one task per scenario.
  Assumes hdl/ is on the include path and stp_pkg is compiled before this file.
*/
`include "stp_regs.svh"

module tb_stp_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import stp_pkg::*;

  // ***************************************************
  // stimulus and observation
  // ***************************************************
  logic        ref_clk         = 1'b0;
  logic        rst_n           = 1'b0;
  logic        sleep           = 1'b0;
  logic        psel            = 1'b0;
  logic        pen             = 1'b0;
  logic        pw              = 1'b0;
  logic [7:0]  paddr           = 8'h00;
  logic [31:0] pwdata          = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        er;
  logic [15:0] cnt;
  int          fail_count      = 0;
  int          samples_checked = 0;

  always #4 ref_clk = ~ref_clk;

  stp_timer uut (
    .i_ref_clk (ref_clk),
    .i_rst_n   (rst_n),
    .i_sleep   (sleep),
    .i_psel    (psel),
    .i_penable (pen),
    .i_pwrite  (pw),
    .i_paddr   (paddr),
    .i_pwdata  (pwdata),
    .o_prdata  (prdata),
    .o_pready  (pready),
    .o_pslverr (pslverr),
    .o_irq     (irq)
  );

  // ***************************************************
  // shared tasks
  // ***************************************************
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_near(input logic [15:0] got, input int exp, input int tol);
    samples_checked++;
    if ($isunknown(got) || int'(got) > exp + tol || int'(got) + tol < exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1; pen <= 1'b0; pw <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    pen <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 20) begin
      fail_count++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic rd_count(output logic [15:0] c);
    apb(1'b0, `STP_ADDR_LOW, 32'h0);
    c[7:0] = rd[7:0];
    apb(1'b0, `STP_ADDR_HIGH, 32'h0);
    c[15:8] = rd[7:0];
  endtask

  task automatic clear_count();
    wr(`STP_ADDR_LOW, 32'h0);
    wr(`STP_ADDR_HIGH, 32'h0);
  endtask

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_regs();
    for (int i = 0; i < 6; i++) rdc(8'(i * 4), 32'h0);
    wr(`STP_ADDR_CTRL, 32'hcc);
    rdc(`STP_ADDR_CTRL, 32'h0);
    wr(`STP_ADDR_CTRL, 32'hfe);
    rdc(`STP_ADDR_CTRL, 32'h32);
    wr(`STP_ADDR_CTRL, 32'h0);
    wr(8'h18, 32'hff);
    chk(32'(er), 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
  endtask

  task automatic t_bytes();
    wr(`STP_ADDR_LOW, 32'h12);
    wr(`STP_ADDR_HIGH, 32'ha5);
    rdc(`STP_ADDR_LOW, 32'h12);
    rdc(`STP_ADDR_HIGH, 32'ha5);
    repeat (500) @(posedge ref_clk);
    rdc(`STP_ADDR_LOW, 32'h12);
  endtask

  task automatic t_rate();
    logic [15:0] held;
    for (int cs = 0; cs < 2; cs++) begin
      for (int ps = 0; ps < 4; ps++) begin
        clear_count();
        wr(`STP_ADDR_CTRL, 32'((ps << 4) | (cs << 1) | 1));
        repeat (4000) @(posedge ref_clk);
        wr(`STP_ADDR_CTRL, 32'((ps << 4) | (cs << 1)));
        rd_count(held);
        chk_near(held, 4000 * (cs ? 8 : 2) / (125 * (1 << ps)), 2);
        repeat (300) @(posedge ref_clk);
        rd_count(cnt);
        chk(32'(cnt), 32'(held));
      end
    end
  endtask

  task automatic t_prescale();
    clear_count();
    wr(`STP_ADDR_CTRL, 32'h31);
    repeat (400) @(posedge ref_clk);
    wr(`STP_ADDR_LOW, 32'h0);
    repeat (300) @(posedge ref_clk);
    wr(`STP_ADDR_CTRL, 32'h30);
    rdc(`STP_ADDR_LOW, 32'h0);
  endtask

  task automatic t_sleep();
    clear_count();
    @(posedge ref_clk) sleep <= 1'b1;
    wr(`STP_ADDR_CTRL, 32'h03);
    repeat (1000) @(posedge ref_clk);
    rdc(`STP_ADDR_LOW, 32'h0);
    wr(`STP_ADDR_CTRL, 32'h0);
    @(posedge ref_clk) sleep <= 1'b0;
  endtask

  task automatic t_roll();
    wr(`STP_ADDR_FLAGS, 32'h0);
    wr(`STP_ADDR_HIGH, 32'hff);
    wr(`STP_ADDR_LOW, 32'hfc);
    wr(`STP_ADDR_CTRL, 32'h03);
    repeat (200) @(posedge ref_clk);
    wr(`STP_ADDR_CTRL, 32'h0);
    rdc(`STP_ADDR_FLAGS, 32'h1);
    rd_count(cnt);
    chk_near(cnt, 9, 2);
    repeat (100) @(posedge ref_clk);
    rdc(`STP_ADDR_FLAGS, 32'h1);
    for (int m = 0; m < 16; m++) begin
      wr(`STP_ADDR_IEN, 32'(m & 1));
      wr(`STP_ADDR_ICTL, 32'(((m >> 1) & 3) << 6));
      wr(`STP_ADDR_CTRL, 32'(32'h30 | ((m >> 3) & 1)));
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'(m == 15));
    end
    wr(`STP_ADDR_FLAGS, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(32'(irq), 32'h0);
    rdc(`STP_ADDR_FLAGS, 32'h0);
    wr(`STP_ADDR_CTRL, 32'h0);
  endtask

  initial begin
    #(80000 * 8);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_bytes();
    t_rate();
    t_prescale();
    t_sleep();
    t_roll();
    tally_and_finish();
  end
endmodule
